// ---- hdl/rtcsm_pkg.sv ----
// Shared constants for the seconds and minutes counters and their APB slave.
package rtcsm_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] SEC_OFFSET  = 12'h000;
   localparam logic [11:0] MIN_OFFSET  = 12'h004;
   localparam logic [11:0] CTRL_OFFSET = 12'h008;

   // Field positions inside the time registers.
   localparam int unsigned UNITS_LSB = 0;
   localparam int unsigned UNITS_MSB = 3;
   localparam int unsigned TENS_LSB  = 4;
   localparam int unsigned TENS_MSB  = 6;
   localparam int unsigned BUSY_BIT  = 7;

   // Field positions inside the control register.
   localparam int unsigned CTRL_RUN_BIT     = 0;
   localparam int unsigned CTRL_FREERUN_BIT = 1;

   // Digit limits of a sixty-step BCD counter.
   localparam logic [3:0] UNITS_MAX = 4'h9;
   localparam logic [2:0] TENS_MAX  = 3'h5;

   // Values after reset.
   localparam logic [6:0] TIME_RESET    = 7'h00;
   localparam logic [7:0] FREERUN_RESET = 8'h00;
   localparam logic       RUN_RESET     = 1'b1;
   localparam logic       FREERUN_MODE_RESET = 1'b0;

   // Timing: one second and the half period of the divided clock, in ns.
   localparam int unsigned PCLK_PERIOD_NS  = 25;
   localparam int unsigned SECOND_NS       = 1_000_000_000;
   localparam int unsigned CLKOUT_HALF_NS  = 500_000_000;
   localparam int unsigned SEC_CYCLES_DEF  = SECOND_NS / PCLK_PERIOD_NS;
   localparam int unsigned CLKOUT_HALF_DEF = CLKOUT_HALF_NS / PCLK_PERIOD_NS;

   // Load value of the lead counter; the busy flag stands this many cycles plus two before the counters step.
   localparam logic [2:0] BUSY_LEAD_CYCLES = 3'h4;

endpackage : rtcsm_pkg

// ---- hdl/rtcsm_cnt_if.sv ----
`timescale 1ns/100ps
// Load, step and result of one sixty-step BCD counter.
interface rtcsm_cnt_if;
   logic       load;
   logic [6:0] load_value;
   logic       inc;
   logic [6:0] value;
   logic       carry;

   modport counter (input load, input load_value, input inc, output value, output carry);
   modport user    (output load, output load_value, output inc, input value, input carry);
endinterface : rtcsm_cnt_if

// ---- hdl/rtcsm_divider.sv ----
`timescale 1ns/100ps
// Free counter that pulses tick once every COUNT cycles while enabled.
module rtcsm_divider #(
   parameter int unsigned COUNT = 8
) (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Control and result.
   input  wire logic enable,
   output logic      tick
);

   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;

   // A stopped divider restarts from zero so the first period is always whole.
   always_comb begin
      tick     = 1'b0;
      cnt_next = cnt_reg;
      if (!enable) begin
         cnt_next = 32'h0000_0000;
      end else if (cnt_reg == 32'(COUNT - 1)) begin
         cnt_next = 32'h0000_0000;
         tick     = 1'b1;
      end else begin
         cnt_next = cnt_reg + 32'h0000_0001;
      end
   end

   // Count register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 32'h0000_0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

endmodule // rtcsm_divider

// ---- hdl/rtcsm_bcd60.sv ----
`timescale 1ns/100ps
// Two-digit BCD counter that runs 00 to 59 and carries on the wrap.
module rtcsm_bcd60 (
   // Clock and reset.
   input  wire logic  pclk,
   input  wire logic  presetn,
   // Counter port.
   rtcsm_cnt_if.counter cnt
);

   logic [6:0] value_reg;
   logic [6:0] value_next;
   logic       carry_c;
   logic [3:0] units;
   logic [2:0] tens;

   assign units     = value_reg[rtcsm_pkg::UNITS_MSB:rtcsm_pkg::UNITS_LSB];
   assign tens      = value_reg[rtcsm_pkg::TENS_MSB:rtcsm_pkg::TENS_LSB];
   assign cnt.value = value_reg;
   assign cnt.carry = carry_c;

   // A load wins over a step, so a preset is never moved by a tick in the same cycle.
   always_comb begin
      value_next = value_reg;
      carry_c    = 1'b0;
      if (cnt.load) begin
         value_next = cnt.load_value;
      end else if (cnt.inc) begin
         if (units >= rtcsm_pkg::UNITS_MAX) begin
            value_next[rtcsm_pkg::UNITS_MSB:rtcsm_pkg::UNITS_LSB] = 4'h0;
            if (tens >= rtcsm_pkg::TENS_MAX) begin
               value_next[rtcsm_pkg::TENS_MSB:rtcsm_pkg::TENS_LSB] = 3'h0;
               carry_c = 1'b1;
            end else begin
               value_next[rtcsm_pkg::TENS_MSB:rtcsm_pkg::TENS_LSB] = tens + 3'h1;
            end
         end else begin
            value_next[rtcsm_pkg::UNITS_MSB:rtcsm_pkg::UNITS_LSB] = units + 4'h1;
         end
      end
   end

   // Digit register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_reg <= rtcsm_pkg::TIME_RESET;
      end else begin
         value_reg <= value_next;
      end
   end

endmodule // rtcsm_bcd60

// ---- hdl/rtcsm_top.sv ----
`timescale 1ns/100ps
// Overview of operation
// RULE_01: A clock divided from the one-second time base is driven on the divided_clock_out pin; the code drives it from a separate pclk divider, u_clk_div.
// RULE_02: The seconds register holds elapsed seconds as two BCD digits from 00 to 59.
// RULE_03: In free-running mode the seconds register reads back as a plain 8-bit counter.
// RULE_04: The seconds tens digit in bits 6 to 4 counts 0 to 5.
// RULE_05: The seconds units digit in bits 3 to 0 counts 0 to 9 each second and bumps the tens digit on wrap.
// RULE_06: Bit 7 of each time register is a read-only busy flag, high while the time values are updated; in free-running mode seconds bit 7 is a count bit.
// RULE_07: Software trusts the time values only when it reads them with the busy flag at zero.
// RULE_08: The minutes register holds 00 to 59 in BCD and steps on the once-per-minute seconds carry.
// RULE_09: The minutes tens digit in bits 6 to 4 counts 0 to 5.
// RULE_10: The minutes units digit in bits 3 to 0 counts 0 to 9 and bumps the tens digit on wrap.
// RULE_11: The minutes wrap yields a carry that advances the hours counter outside this block.
// RULE_12: Seconds wrap from 59 to 00 with one minute carry, and minutes wrap likewise with one hour carry.
// RULE_13: Software may write the digit fields to preset seconds and minutes at any time; the code drops seconds writes in free-running mode.
module rtcsm_top #(
   parameter int unsigned SEC_CYCLES         = rtcsm_pkg::SEC_CYCLES_DEF,
   parameter int unsigned CLKOUT_HALF_CYCLES = rtcsm_pkg::CLKOUT_HALF_DEF
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins and links to the neighbouring counters.
   output logic             divided_clock_out,
   output logic             hour_carry,
   output logic             update_in_progress
);

   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_APPLY} rtcsm_state_t;

   rtcsm_cnt_if sec_if ();
   rtcsm_cnt_if min_if ();

   // Register map, one aligned word each, data in the low byte and upper bits reading zero:
   //   seconds word: bit 7 busy, bits 6 to 4 tens digit, bits 3 to 0 units digit; in free-running
   //   mode all eight bits are the binary free count instead and writes to the word are dropped.
   //   minutes word: bit 7 busy, bits 6 to 4 tens digit, bits 3 to 0 units digit.
   //   control word: bit 0 enables the time base, bit 1 selects free-running mode.
   // Any other address answers with pslverr, drops a write and reads back zero.
   // Digits are stored as written without a range check; a units digit of nine or more or a
   // tens digit of five or more is taken as the wrap point on the next step, so a bad preset
   // heals itself within one wrap instead of counting through undefined codes.

   // Update sequencer state.
   rtcsm_state_t state_reg;
   rtcsm_state_t state_next;
   logic [2:0]   lead_reg;
   logic [2:0]   lead_next;
   logic         busy_reg;
   logic         busy_next;
   logic         apply;

   // Control and free-running state.
   logic         run_reg;
   logic         run_next;
   logic         freerun_mode_reg;
   logic         freerun_mode_next;
   logic [7:0]   freerun_reg;
   logic [7:0]   freerun_next;

   // Output-side state.
   logic         clkout_reg;
   logic         clkout_next;
   logic         hour_carry_reg;
   logic         hour_carry_next;

   // APB state.
   logic [31:0]  prdata_reg;
   logic [31:0]  prdata_next;
   logic         pready_reg;
   logic         pready_next;
   logic         pslverr_reg;
   logic         pslverr_next;

   // Decode helpers.
   logic         sec_tick;
   logic         clk_tick;
   logic         access;
   logic         first_access;
   logic         write_done;
   logic         hit_sec;
   logic         hit_min;
   logic         hit_ctrl;
   logic [31:0]  read_value;

   // One-second time base.
   rtcsm_divider #(.COUNT(SEC_CYCLES)) u_sec_div (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (run_reg),
      .tick    (sec_tick)
   );

   // Time base for the divided clock pin.
   rtcsm_divider #(.COUNT(CLKOUT_HALF_CYCLES)) u_clk_div (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (run_reg),
      .tick    (clk_tick)
   );

   // Seconds digits.
   rtcsm_bcd60 u_sec (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt     (sec_if.counter)
   );

   // Minutes digits.
   rtcsm_bcd60 u_min (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt     (min_if.counter)
   );

   // Address decode; only whole aligned words at the three offsets are mapped.
   assign access       = psel & penable;
   assign first_access = access & ~pready_reg;
   assign write_done   = access & pready_reg & pwrite;
   assign hit_sec      = (paddr == rtcsm_pkg::SEC_OFFSET);
   assign hit_min      = (paddr == rtcsm_pkg::MIN_OFFSET);
   assign hit_ctrl     = (paddr == rtcsm_pkg::CTRL_OFFSET);

   // The minutes counter sees the seconds carry combinationally, so both digit pairs move in
   // the same edge and a reader never finds the seconds wrapped while the minutes lag behind.
   // In free-running mode the BCD seconds and minutes hold still; only the binary count moves.
   // Counter steps and software presets. A preset lands at the edge that completes the write.
   assign sec_if.inc        = apply & ~freerun_mode_reg;                                 // RULE_05
   assign min_if.inc        = sec_if.carry;                                              // RULE_08
   assign sec_if.load       = write_done & hit_sec & ~freerun_mode_reg;                  // RULE_13
   assign min_if.load       = write_done & hit_min;                                      // RULE_13
   assign sec_if.load_value = pwdata[6:0];
   assign min_if.load_value = pwdata[6:0];

   // Busy flag leads the step by a few cycles, so a reader that sees it low
   // knows the digits will not move before its read completes.
   // Timeline of one update, counted from the edge after the one-second tick:
   //   edge 0     busy rises and the lead counter is loaded.
   //   edges 1-4  the lead counter runs down while the digits hold still.
   //   edge 5     the sequencer enters the apply state with busy still high.
   //   edge 6     the digits (or the free count) step and busy falls in the same edge.
   // Busy therefore stands for six cycles. Busy and the digits enter the read data at the same
   // edge, so a reply that shows busy low always carries a whole, settled time.
   // The sequencer keeps running when the time base is stopped, so an update in flight completes.
   always_comb begin
      state_next = state_reg;
      lead_next  = lead_reg;
      apply      = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (sec_tick) begin
               state_next = ST_BUSY;
               lead_next  = rtcsm_pkg::BUSY_LEAD_CYCLES;
            end
         end
         ST_BUSY: begin
            if (lead_reg == 3'h0) begin
               state_next = ST_APPLY;
            end else begin
               lead_next = lead_reg - 3'h1;
            end
         end
         ST_APPLY: begin
            apply      = 1'b1;
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      busy_next = (state_next != ST_IDLE);                                               // RULE_06
   end

   // Sequencer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         lead_reg  <= 3'h0;
         busy_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         lead_reg  <= lead_next;
         busy_reg  <= busy_next;
      end
   end

   // Stopping the time base clears both dividers, so a restart gives a full first second and
   // a full first half period on the pin; the cost is that a stop and restart loses the part
   // of the second that had already elapsed.
   // Control bits and the free-running count. A write to the count is ignored
   // because it is read-only in that mode.
   always_comb begin
      run_next          = run_reg;
      freerun_mode_next = freerun_mode_reg;
      freerun_next      = freerun_reg;
      if (apply && freerun_mode_reg) begin
         freerun_next = freerun_reg + 8'h01;                                             // RULE_03
      end
      if (write_done && hit_ctrl) begin
         run_next          = pwdata[rtcsm_pkg::CTRL_RUN_BIT];
         freerun_mode_next = pwdata[rtcsm_pkg::CTRL_FREERUN_BIT];
      end
   end

   // Control registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg          <= rtcsm_pkg::RUN_RESET;
         freerun_mode_reg <= rtcsm_pkg::FREERUN_MODE_RESET;
         freerun_reg      <= rtcsm_pkg::FREERUN_RESET;
      end else begin
         run_reg          <= run_next;
         freerun_mode_reg <= freerun_mode_next;
         freerun_reg      <= freerun_next;
      end
   end

   // Pin toggle and the outgoing hour carry, a one-cycle pulse per minutes wrap.
   // The carry is registered, so it rises at the same edge that the minutes digits wrap to 00; the hours counter
   // outside must take it as a one-cycle pulse and not as a level.
   always_comb begin
      clkout_next     = clk_tick ? ~clkout_reg : clkout_reg;                             // RULE_01
      hour_carry_next = min_if.carry;                                                    // RULE_11 RULE_12
   end

   // Pin and carry registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clkout_reg     <= 1'b0;
         hour_carry_reg <= 1'b0;
      end else begin
         clkout_reg     <= clkout_next;
         hour_carry_reg <= hour_carry_next;
      end
   end

   // Read multiplexer; the busy flag rides in bit 7 of both time registers.
   // The free count replaces the whole seconds word, busy flag included, because all eight
   // bits are needed for the count; software in that mode can still see busy in the minutes word.
   always_comb begin
      read_value = 32'h0000_0000;
      if (hit_sec) begin
         if (freerun_mode_reg) begin
            read_value[7:0] = freerun_reg;                                               // RULE_03
         end else begin
            read_value[rtcsm_pkg::BUSY_BIT] = busy_reg;                                  // RULE_06
            read_value[6:0] = sec_if.value;                                              // RULE_02 RULE_04
         end
      end else if (hit_min) begin
         read_value[rtcsm_pkg::BUSY_BIT] = busy_reg;                                     // RULE_06
         read_value[6:0] = min_if.value;                                                 // RULE_09 RULE_10
      end else if (hit_ctrl) begin
         read_value[rtcsm_pkg::CTRL_RUN_BIT]     = run_reg;
         read_value[rtcsm_pkg::CTRL_FREERUN_BIT] = freerun_mode_reg;
      end
   end

   // Transfer timing seen from the bus:
   //   setup cycle     psel high, penable low; nothing is decoded yet.
   //   first access    psel and penable high, pready low; read data and pslverr are latched.
   //   second access   pready high for one cycle; a write lands at the edge that ends it.
   // A master that keeps psel and penable up after pready gets a fresh answer two cycles later,
   // because first_access rearms once pready has dropped.
   // Every access takes one wait state so that pready and prdata come from flops.
   always_comb begin
      pready_next  = first_access;
      pslverr_next = first_access & ~(hit_sec | hit_min | hit_ctrl);
      prdata_next  = prdata_reg;
      if (first_access && !pwrite) begin
         prdata_next = read_value;
      end
   end

   // APB answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   // Outputs straight from flops.
   assign prdata             = prdata_reg;
   assign pready             = pready_reg;
   assign pslverr            = pslverr_reg;
   assign divided_clock_out  = clkout_reg;
   assign hour_carry         = hour_carry_reg;
   assign update_in_progress = busy_reg;

endmodule // rtcsm_top

// ---- bench/rtcsm_chk.sv ----
`timescale 1ns/100ps
// Port level checks for the seconds and minutes counters.
module rtcsm_chk #(
   parameter int unsigned SEC_CYCLES         = 16,
   parameter int unsigned CLKOUT_HALF_CYCLES = 8
) (
   // Clock and reset.
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins.
   input wire logic        divided_clock_out,
   input wire logic        hour_carry,
   input wire logic        update_in_progress
);
   logic [15:0] gap_reg;
   logic        dco_q_reg;
   logic [15:0] tick_gap_reg;
   logic        busy_q_reg;

   // Cycles since the divided clock moved; it saturates so a frozen clock never wraps into a short gap.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg   <= 16'hffff;
         dco_q_reg <= 1'b0;
      end else begin
         dco_q_reg <= divided_clock_out;
         if (divided_clock_out != dco_q_reg) begin
            gap_reg <= 16'h0000;
         end else if (gap_reg != 16'hffff) begin
            gap_reg <= gap_reg + 16'h0001;
         end
      end
   end

   // Cycles since the last update began; a control write may restart the time base, so it
   // voids the measurement until the next update.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_gap_reg <= 16'hffff;
         busy_q_reg   <= 1'b0;
      end else begin
         busy_q_reg <= update_in_progress;
         if (psel && penable && pready && pwrite && paddr == rtcsm_pkg::CTRL_OFFSET) begin
            tick_gap_reg <= 16'hffff;
         end else if (update_in_progress && !busy_q_reg) begin
            tick_gap_reg <= 16'h0000;
         end else if (tick_gap_reg != 16'hffff) begin
            tick_gap_reg <= tick_gap_reg + 16'h0001;
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long.");
   apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late.");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone.");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set.");
   busy_bit_a: assert property (pready && !pwrite && paddr == rtcsm_pkg::MIN_OFFSET
      |-> prdata[7] == $past(update_in_progress)) else $error("busy bit differs.");
   min_bcd_a: assert property (pready && !pwrite && paddr == rtcsm_pkg::MIN_OFFSET
      |-> prdata[3:0] <= rtcsm_pkg::UNITS_MAX && prdata[6:4] <= rtcsm_pkg::TENS_MAX) else $error("minutes not BCD.");
   busy_len_a: assert property ($rose(update_in_progress)
      |-> update_in_progress [*6] ##1 !update_in_progress) else $error("busy length wrong.");
   carry_pulse_a: assert property (hour_carry |=> !hour_carry) else $error("carry too long.");
   carry_after_step_a: assert property (hour_carry
      |-> !update_in_progress && ($past(update_in_progress) || $past(update_in_progress, 2)))
      else $error("carry outside a step.");
   clkout_gap_a: assert property (divided_clock_out != dco_q_reg
      |-> gap_reg >= CLKOUT_HALF_CYCLES - 1) else $error("divided clock too fast.");
   busy_period_a: assert property ($rose(update_in_progress) && tick_gap_reg != 16'hffff
      |-> tick_gap_reg == SEC_CYCLES - 1) else $error("update period wrong.");
endmodule // rtcsm_chk

bind rtcsm_top rtcsm_chk #(.SEC_CYCLES(SEC_CYCLES), .CLKOUT_HALF_CYCLES(CLKOUT_HALF_CYCLES)) rtcsm_chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .divided_clock_out(divided_clock_out), .hour_carry(hour_carry), .update_in_progress(update_in_progress));

// ---- bench/tb.sv ----
`timescale 1ns/100ps
// Self-checking bench for the seconds and minutes counters behind APB.
module tb;
   localparam int unsigned SEC_N  = 40;
   localparam int unsigned HALF_N = 8;
   localparam logic [11:0] A_SEC  = rtcsm_pkg::SEC_OFFSET;
   localparam logic [11:0] A_MIN  = rtcsm_pkg::MIN_OFFSET;
   localparam logic [11:0] A_CTL  = rtcsm_pkg::CTRL_OFFSET;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dco, carry, busy, err, dco0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v0;
   int          num_errors, checked, carries, gap;
   // Preset seconds, preset minutes, expected seconds and minutes one step later.
   logic [7:0]  cases [4][4] = '{'{8'h09, 8'h00, 8'h10, 8'h00}, '{8'h58, 8'h00, 8'h59, 8'h00},
                                 '{8'h59, 8'h09, 8'h00, 8'h10}, '{8'h59, 8'h59, 8'h00, 8'h00}};

   rtcsm_top #(.SEC_CYCLES(SEC_N), .CLKOUT_HALF_CYCLES(HALF_N)) rtcsm_top_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .divided_clock_out(dco), .hour_carry(carry), .update_in_progress(busy));

   // A 25 ns clock.
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   // Hour carry pulses are counted so that a doubled or missing one shows.
   always @(posedge pclk) begin
      if (carry === 1'b1) begin
         carries <= carries + 1;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("apb answer", 32'(n < 20), 32'h1);
   endtask

   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 200) begin
         @(posedge pclk);
         n++;
      end
      check("busy wait", 32'(n < 200), 32'h1);
   endtask

   // Values are read only after busy falls, which leaves a quiet window before the next tick.
   task automatic step(input int k);
      repeat (k) begin
         wait_busy(1'b1);
         wait_busy(1'b0);
      end
   endtask

   task automatic clk_gap();
      logic last;
      last = dco;
      gap = 0;
      while (dco === last && gap < 100) begin
         @(posedge pclk);
         gap++;
      end
      last = dco;
      gap = 0;
      while (dco === last && gap < 100) begin
         @(posedge pclk);
         gap++;
      end
   endtask

   // Watchdog at four thousand cycles, several times the length of a clean run.
   initial begin
      #(25 * 20 * 200);
      num_errors++;
      report_and_stop();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {num_errors, checked, carries} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_CTL, 32'h0);
      check("control reset", rd, 32'h0000_0001);
      check("mapped error", 32'(err), 32'h0);
      apb(1'b0, A_SEC, 32'h0);
      check("seconds reset", rd, 32'h0);
      apb(1'b0, A_MIN, 32'h0);
      check("minutes reset", rd, 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      check("unmapped read", {rd[30:0], err}, 32'h1);
      apb(1'b1, 12'h010, 32'h0000_0059);
      check("unmapped write", 32'(err), 32'h1);
      wait_busy(1'b1);
      apb(1'b0, A_MIN, 32'h0);
      check("busy flag", 32'(rd[7]), 32'h1);
      clk_gap();
      check("divided clock", 32'(gap), 32'(HALF_N));
      for (int i = 0; i < 4; i++) begin
         step(1);
         apb(1'b1, A_SEC, {24'h00_0000, cases[i][0]});
         apb(1'b1, A_MIN, {24'h00_0000, cases[i][1]});
         step(1);
         apb(1'b0, A_SEC, 32'h0);
         check("seconds step", rd, {24'h00_0000, cases[i][2]});
         apb(1'b0, A_MIN, 32'h0);
         check("minutes step", rd, {24'h00_0000, cases[i][3]});
      end
      check("hour carries", 32'(carries), 32'h1);
      step(1);
      apb(1'b1, A_CTL, 32'h0000_0003);
      step(1);
      apb(1'b0, A_SEC, 32'h0);
      v0 = rd;
      apb(1'b1, A_SEC, 32'h0000_0012);
      step(2);
      apb(1'b0, A_SEC, 32'h0);
      check("free count", rd, {24'h00_0000, v0[7:0] + 8'h02});
      apb(1'b1, A_CTL, 32'h0000_0000);
      apb(1'b0, A_SEC, 32'h0);
      check("seconds frozen", rd, 32'h0000_0001);
      dco0 = dco;
      repeat (3 * SEC_N) @(posedge pclk);
      apb(1'b0, A_SEC, 32'h0);
      check("stopped seconds", rd, 32'h0000_0001);
      check("stopped clock", 32'(dco), 32'(dco0));
      check("stopped busy", 32'(busy), 32'h0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_CTL, 32'h0);
      check("control after reset", rd, 32'h0000_0001);
      apb(1'b0, A_SEC, 32'h0);
      check("seconds after reset", rd, 32'h0);
      report_and_stop();
   end
endmodule // tb
